// ===== pkg/gso_pkg.sv
// Package of constants for the gate scan order and pin state block
`default_nettype none
package gso_pkg;
  // =========================================================
  // Register map (plain port, word index = address)
  localparam logic [3:0] ADDR_SCAN_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_OSC_ADJ     = 4'h1;
  localparam logic [3:0] ADDR_GAMMA_NEG   = 4'h2;
  localparam logic [3:0] ADDR_STATUS      = 4'h3;
  localparam logic [3:0] ADDR_SOFT_RESET  = 4'h4;
  localparam logic [3:0] ADDR_LINE_PERIOD = 4'h5;
  localparam logic [3:0] ADDR_PIN_CTRL    = 4'h6;
  // =========================================================
  // Field positions
  localparam int SCAN_REV_BIT   = 0;
  localparam int SCAN_ILACE_BIT = 1;
  localparam int SCAN_RUN_BIT   = 2;
  localparam int PIN_TE_BIT     = 0;
  localparam int PIN_VS_BIT     = 1;
  localparam int PIN_TEST_BIT   = 2;
  localparam int PIN_STBY_BIT   = 3;
  // =========================================================
  // Geometry and reset values
  localparam logic [8:0]  NUM_LINES        = 9'h140;
  localparam logic [8:0]  FIRST_LINE       = 9'h001;
  localparam logic [8:0]  LAST_ODD         = 9'h13f;
  localparam logic [8:0]  FIRST_EVEN       = 9'h002;
  localparam logic [3:0]  OSC_ADJ_RESET    = 4'h0;
  localparam logic [15:0] LINE_PERIOD_RST  = 16'h0010;
  localparam int          OSC_DEFAULT_KHZ  = 5500;
  localparam int          GAMMA_POINTS     = 6;
  // =========================================================
  // Bus widths
  localparam int DATA_W = 18;
  localparam int ADDR_W = 4;
endpackage : gso_pkg
`default_nettype wire

// ===== hw/gso_sync3.sv
// Three-stage input synchroniser with agreement check
`timescale 1ns/1ps
`default_nettype none
module gso_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // Only s2 reads s1; a change counts once s2 and s3 agree
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      sync_out <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          sync_out[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule : gso_sync3
`default_nettype wire

// ===== hw/gso_scan_top.sv
// Gate scan order sequencer with oscillator select, gamma taps and pin states
// Functional notes
// [R1] Gate order is chosen by the pair interlace_select and reverse_direction.
// [R2] With both bits clear lines run 1 up to 320.
// [R3] With only reverse_direction set lines run 320 down to 1.
// [R4] With only interlace_select set odd lines 1..319 run, then even lines 2..320.
// [R5] With both set even lines 320..2 run, then odd lines 319..1.
// [R6] After any reset the tearing, vsync and test outputs are low.
// [R7] After any reset the data bus drivers are inactive.
// [R8] The data bus is released at the first clock edge that samples reset or a software reset; until that edge it keeps its last state.
// [R9] Host strobes, data, sync, pixel clock, enable and straps are sampled in every state; the synchronisers are held clear while reset_in is high.
// [R10] The oscillator frequency setting comes from the four-bit osc_freq_adjust field.
// [R11] Out of reset osc_freq_adjust holds its default code, giving 5.5 MHz.
// [R12] No sleep state exists in this mode; only standby reduces power.
// [R13] Each negative gamma point picks ladder tap 1..8 from codes 000..111 in order.
// [R14] The sequencer steps one line per line period and wraps to the order's first line each frame.
`timescale 1ns/1ps
`default_nettype none
module gso_scan_top (
  input  wire logic                      clk_in,
  input  wire logic                      reset_in,
  input  wire logic [gso_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [31:0]               wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [31:0]               rdata_out,
  input  wire logic                      chip_select_n_in,
  input  wire logic                      cmd_data_select_in,
  input  wire logic                      write_strobe_n_in,
  input  wire logic                      read_strobe_n_in,
  input  wire logic [gso_pkg::DATA_W-1:0] host_data_bus_in,
  output logic      [gso_pkg::DATA_W-1:0] host_data_bus_out,
  output logic                           host_data_bus_oe_out,
  input  wire logic                      pixel_clock_in,
  input  wire logic                      enable_in,
  input  wire logic                      bus_style_strap_in,
  input  wire logic                      bus_width_strap2_in,
  input  wire logic                      extended_cmd_strap_in,
  output logic      [8:0]                gate_line_out,
  output logic                           gate_strobe_out,
  output logic                           frame_start_out,
  output logic      [3:0]                osc_freq_adjust_out,
  output logic      [17:0]               neg_gamma_tap_out,
  output logic                           tearing_effect_out,
  output logic                           vsync_out,
  output logic                           test_output_out,
  output logic                           standby_out
);
  // =========================================================
  // Types and helpers
  typedef enum logic [1:0] {GSO_SEQ_UP, GSO_SEQ_DOWN, GSO_ODD_EVEN_UP, GSO_EVEN_ODD_DOWN} gso_order_t;
  typedef enum logic [1:0] {GSO_IDLE, GSO_PASS1, GSO_PASS2} gso_state_t;

  // Ladder tap number 1..8 from a three-bit code, ascending
  function automatic logic [2:0] tap_of(input logic [2:0] code);
    tap_of = code;
  endfunction : tap_of

  function automatic gso_order_t order_of(input logic ilace, input logic rev);
    case ({ilace, rev})
      2'b00:   order_of = GSO_SEQ_UP;
      2'b01:   order_of = GSO_SEQ_DOWN;
      2'b10:   order_of = GSO_ODD_EVEN_UP;
      default: order_of = GSO_EVEN_ODD_DOWN;
    endcase
  endfunction : order_of

  function automatic logic [8:0] first_line_of(input gso_order_t ord);
    case (ord)
      GSO_SEQ_UP, GSO_ODD_EVEN_UP: first_line_of = gso_pkg::FIRST_LINE;
      default:                     first_line_of = gso_pkg::NUM_LINES;
    endcase
  endfunction : first_line_of

  // =========================================================
  // Pin synchronisers
  logic [7:0] pins_sync;
  logic [gso_pkg::DATA_W-1:0] data_sync;

  // Active-low strobes enter inverted so the reset value reads as idle
  gso_sync3 #(.W(8)) u_sync_ctl (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in ({~chip_select_n_in, cmd_data_select_in, ~write_strobe_n_in, ~read_strobe_n_in,
                pixel_clock_in, enable_in, bus_style_strap_in,
                bus_width_strap2_in ^ extended_cmd_strap_in}),
    .sync_out (pins_sync)
  );  // [R9]

  gso_sync3 #(.W(gso_pkg::DATA_W)) u_sync_data (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (host_data_bus_in),
    .sync_out (data_sync)
  );  // [R9]

  // =========================================================
  // Registers
  logic        rev_ff;
  logic        ilace_ff;
  logic        run_ff;
  logic [3:0]  osc_adj_ff;
  logic [17:0] gamma_ff;
  logic [15:0] period_ff;
  logic        te_en_ff;
  logic        vs_en_ff;
  logic        test_en_ff;
  logic        stby_ff;
  logic        soft_rst_ff;
  logic        any_rst;

  assign any_rst = reset_in | soft_rst_ff;

  // Soft reset lasts one cycle after the write
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= wr_in && (addr_in == gso_pkg::ADDR_SOFT_RESET) && wdata_in[0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      rev_ff     <= 1'b0;
      ilace_ff   <= 1'b0;
      run_ff     <= 1'b0;
      osc_adj_ff <= gso_pkg::OSC_ADJ_RESET;  // [R11]
      gamma_ff   <= '0;
      period_ff  <= gso_pkg::LINE_PERIOD_RST;
      te_en_ff   <= 1'b0;
      vs_en_ff   <= 1'b0;
      test_en_ff <= 1'b0;
      stby_ff    <= 1'b0;
    end else if (wr_in) begin
      case (addr_in)
        gso_pkg::ADDR_SCAN_CTRL: begin
          rev_ff   <= wdata_in[gso_pkg::SCAN_REV_BIT];
          ilace_ff <= wdata_in[gso_pkg::SCAN_ILACE_BIT];
          run_ff   <= wdata_in[gso_pkg::SCAN_RUN_BIT];
        end
        gso_pkg::ADDR_OSC_ADJ:     osc_adj_ff <= wdata_in[3:0];  // [R10]
        gso_pkg::ADDR_GAMMA_NEG:   gamma_ff   <= wdata_in[17:0];
        gso_pkg::ADDR_LINE_PERIOD: period_ff  <= (wdata_in[15:0] == 16'h0000) ? 16'h0001 : wdata_in[15:0];
        gso_pkg::ADDR_PIN_CTRL: begin
          te_en_ff   <= wdata_in[gso_pkg::PIN_TE_BIT];
          vs_en_ff   <= wdata_in[gso_pkg::PIN_VS_BIT];
          test_en_ff <= wdata_in[gso_pkg::PIN_TEST_BIT];
          stby_ff    <= wdata_in[gso_pkg::PIN_STBY_BIT];  // [R12]
        end
        default: ;
      endcase
    end
  end

  // =========================================================
  // Scan sequencer
  gso_state_t  state_ff;
  gso_order_t  order_ff;
  logic [8:0]  line_ff;
  logic [15:0] tick_ff;
  logic        step;

  assign step = (tick_ff == period_ff - 16'h0001);

  // Line period divider gives a one-cycle enable
  always_ff @(posedge clk_in) begin
    if (any_rst || !run_ff || stby_ff || step) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= tick_ff + 16'h0001;
    end
  end  // [R14]

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      state_ff <= GSO_IDLE;
      order_ff <= GSO_SEQ_UP;
      line_ff  <= gso_pkg::FIRST_LINE;
      frame_start_out <= 1'b0;
      gate_strobe_out <= 1'b0;
    end else begin
      frame_start_out <= 1'b0;
      gate_strobe_out <= 1'b0;
      case (state_ff)
        GSO_IDLE: begin
          if (run_ff && !stby_ff && step) begin
            // Order is latched on leaving idle and at the sequential-up wrap, so a mid-frame write cannot tear it
            order_ff <= order_of(ilace_ff, rev_ff);  // [R1]
            state_ff <= GSO_PASS1;
            frame_start_out <= 1'b1;
            gate_strobe_out <= 1'b1;
            line_ff  <= first_line_of(order_of(ilace_ff, rev_ff));  // [R14]
          end
        end
        GSO_PASS1, GSO_PASS2: begin
          if (!run_ff || stby_ff) begin
            state_ff <= GSO_IDLE;
          end else if (step) begin
            gate_strobe_out <= 1'b1;
            case (order_ff)
              GSO_SEQ_UP: begin
                if (line_ff == gso_pkg::NUM_LINES) begin
                  // A changed order starts on its own first line
                  line_ff <= first_line_of(order_of(ilace_ff, rev_ff));
                  frame_start_out <= 1'b1;
                  order_ff <= order_of(ilace_ff, rev_ff);
                end else begin
                  line_ff <= line_ff + 9'h001;
                end
              end  // [R2]
              GSO_SEQ_DOWN: begin
                if (line_ff == gso_pkg::FIRST_LINE) begin
                  line_ff <= gso_pkg::NUM_LINES;
                  frame_start_out <= 1'b1;
                end else begin
                  line_ff <= line_ff - 9'h001;
                end
              end  // [R3]
              GSO_ODD_EVEN_UP: begin
                if (line_ff == gso_pkg::LAST_ODD) begin
                  line_ff  <= gso_pkg::FIRST_EVEN;
                  state_ff <= GSO_PASS2;
                end else if (line_ff == gso_pkg::NUM_LINES) begin
                  line_ff  <= gso_pkg::FIRST_LINE;
                  state_ff <= GSO_PASS1;
                  frame_start_out <= 1'b1;
                end else begin
                  line_ff <= line_ff + 9'h002;
                end
              end  // [R4]
              default: begin
                if (line_ff == gso_pkg::FIRST_EVEN) begin
                  line_ff  <= gso_pkg::LAST_ODD;
                  state_ff <= GSO_PASS2;
                end else if (line_ff == gso_pkg::FIRST_LINE) begin
                  line_ff  <= gso_pkg::NUM_LINES;
                  state_ff <= GSO_PASS1;
                  frame_start_out <= 1'b1;
                end else begin
                  line_ff <= line_ff - 9'h002;
                end
              end  // [R5]
            endcase
          end
        end
        default: state_ff <= GSO_IDLE;
      endcase
    end
  end  // [R14]

  // Line number trails its strobe by one cycle
  always_ff @(posedge clk_in) begin
    gate_line_out <= line_ff;
  end

  // =========================================================
  // Pin outputs
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      tearing_effect_out   <= 1'b0;  // [R6]
      vsync_out            <= 1'b0;  // [R6]
      test_output_out      <= 1'b0;  // [R6]
      host_data_bus_oe_out <= 1'b0;  // [R7] [R8]
      host_data_bus_out    <= '0;
      osc_freq_adjust_out  <= gso_pkg::OSC_ADJ_RESET;
      neg_gamma_tap_out    <= '0;
      standby_out          <= 1'b0;
    end else begin
      tearing_effect_out   <= te_en_ff && frame_start_out;
      vsync_out            <= vs_en_ff && frame_start_out;
      test_output_out      <= test_en_ff && gate_strobe_out;
      // Drive the data bus only for a selected host read strobe
      host_data_bus_oe_out <= pins_sync[7] && pins_sync[4];
      host_data_bus_out    <= {9'h000, line_ff};
      osc_freq_adjust_out  <= osc_adj_ff;  // [R10]
      for (int p = 0; p < gso_pkg::GAMMA_POINTS; p++) begin
        neg_gamma_tap_out[p*3 +: 3] <= tap_of(gamma_ff[p*3 +: 3]);  // [R13]
      end
      standby_out          <= stby_ff;  // [R12]
    end
  end

  // =========================================================
  // Read port
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        gso_pkg::ADDR_SCAN_CTRL:   rdata_out <= {29'h0, run_ff, ilace_ff, rev_ff};
        gso_pkg::ADDR_OSC_ADJ:     rdata_out <= {28'h0, osc_adj_ff};
        gso_pkg::ADDR_GAMMA_NEG:   rdata_out <= {14'h0, gamma_ff};
        gso_pkg::ADDR_STATUS:      rdata_out <= {12'h0, data_sync[0], pins_sync, state_ff, line_ff};
        gso_pkg::ADDR_LINE_PERIOD: rdata_out <= {16'h0, period_ff};
        gso_pkg::ADDR_PIN_CTRL:    rdata_out <= {28'h0, stby_ff, test_en_ff, vs_en_ff, te_en_ff};
        default:                   rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  // =========================================================
  // Checks
  a_reset_pins_low: assert property (@(posedge clk_in) $past(any_rst) |->
    !tearing_effect_out && !vsync_out && !test_output_out) else $error("pins not low after reset");  // [R6]
  a_bus_released: assert property (@(posedge clk_in) $past(any_rst) |-> !host_data_bus_oe_out)
    else $error("data bus driven after reset");  // [R7] [R8]
  a_osc_default: assert property (@(posedge clk_in) $past(reset_in) |-> osc_adj_ff == gso_pkg::OSC_ADJ_RESET)
    else $error("oscillator code not default");  // [R11]
  a_osc_follow: assert property (@(posedge clk_in) disable iff (any_rst)
    $past(wr_in && addr_in == gso_pkg::ADDR_OSC_ADJ) |=> osc_freq_adjust_out == $past(wdata_in[3:0], 2))
    else $error("oscillator code not applied");  // [R10]
  a_seq_up_step: assert property (@(posedge clk_in) disable iff (any_rst)
    state_ff == GSO_PASS1 && order_ff == GSO_SEQ_UP && step && run_ff && !stby_ff
    && line_ff != gso_pkg::NUM_LINES |=> line_ff == $past(line_ff) + 9'h001)
    else $error("sequential step wrong");  // [R2]
  a_seq_down_step: assert property (@(posedge clk_in) disable iff (any_rst)
    order_ff == GSO_SEQ_DOWN && state_ff == GSO_PASS1 && step && run_ff && !stby_ff
    && line_ff != gso_pkg::FIRST_LINE |=> line_ff == $past(line_ff) - 9'h001)
    else $error("reverse step wrong");  // [R3]
  a_odd_to_even: assert property (@(posedge clk_in) disable iff (any_rst)
    order_ff == GSO_ODD_EVEN_UP && state_ff != GSO_IDLE && step && run_ff && !stby_ff
    && line_ff == gso_pkg::LAST_ODD |=> line_ff == gso_pkg::FIRST_EVEN && state_ff == GSO_PASS2)
    else $error("odd pass did not hand to even");  // [R4]
  a_even_to_odd: assert property (@(posedge clk_in) disable iff (any_rst)
    order_ff == GSO_EVEN_ODD_DOWN && state_ff != GSO_IDLE && step && run_ff && !stby_ff
    && line_ff == gso_pkg::FIRST_EVEN |=> line_ff == gso_pkg::LAST_ODD)
    else $error("even pass did not hand to odd");  // [R5]
  a_gamma_tap: assert property (@(posedge clk_in) disable iff (any_rst)
    $past(!any_rst) |-> neg_gamma_tap_out[2:0] == $past(gamma_ff[2:0]))
    else $error("gamma tap mismatch");  // [R13]
endmodule : gso_scan_top
`default_nettype wire

// ===== test/gso_host_pins.sv
// Host side pin model: strobes, pixel clock and enable pins, shared data wire
`timescale 1ns/1ps
`default_nettype none
module gso_host_pins (
  input  wire logic        clk_in,
  input  wire logic        read_req_in,
  input  wire logic [17:0] dev_data_in,
  input  wire logic        dev_oe_in,
  output logic             chip_select_n_out,
  output logic             cmd_data_select_out,
  output logic             write_strobe_n_out,
  output logic             read_strobe_n_out,
  output logic             pixel_clock_out,
  output logic             enable_out,
  output logic [17:0]      bus_wire_out
);
  logic [2:0]  cnt_ff;
  logic [17:0] float_ff;
  initial begin
    cnt_ff = 3'h0;
    float_ff = 18'h2aaaa;
  end
  // =========================================================
  // Pins keep moving in every state, reset included
  always @(posedge clk_in) begin
    cnt_ff <= cnt_ff + 3'h1;
    float_ff <= ~float_ff;
  end
  assign chip_select_n_out   = ~read_req_in;
  assign read_strobe_n_out   = ~read_req_in;
  assign cmd_data_select_out = cnt_ff[1];
  assign write_strobe_n_out  = read_req_in | ~(cnt_ff == 3'h5);
  assign pixel_clock_out     = cnt_ff[0];
  assign enable_out          = cnt_ff[2];
  // =========================================================
  // Released wire shows a changing pattern during a host read, a held 0155a otherwise
  always_comb begin
    if (dev_oe_in === 1'b1) bus_wire_out = dev_data_in;
    else if (read_req_in) bus_wire_out = float_ff;
    else bus_wire_out = 18'h0155a;
  end
endmodule : gso_host_pins
`default_nettype wire

// ===== test/gso_scan_order_pin_states_tb_top.sv
// Self-checking bench for the gate scan order and pin state block
`timescale 1ns/1ps
`default_nettype none
module gso_scan_order_pin_states_tb_top;
  typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} gso_row_t;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [3:0]  addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        read_req = 1'b0;
  logic [31:0] rdata_out, v;
  logic        cs_n, cds, wr_n, rd_n, pclk, en, oe, te, vs, tst, stby, gstb, fstart;
  logic [17:0] wire_bus, dbus_out, gamma;
  logic [8:0]  gline;
  logic [3:0]  osc;
  int          n_fail = 0;
  int          check_count = 0;
  gso_row_t    rows [8] = '{
    '{4'h1, 32'ha, 32'ha}, '{4'h1, 32'hf, 32'hf},
    '{4'h2, 32'h14e5, 32'h14e5}, '{4'h2, 32'h3e, 32'h3e},
    '{4'h5, 32'h0, 32'h1}, '{4'h5, 32'h2, 32'h2},
    '{4'h6, 32'h8, 32'h8}, '{4'h7, 32'hffff, 32'h0}};

  always #4 clk_in = ~clk_in;

  gso_scan_top uut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .chip_select_n_in(cs_n),
    .cmd_data_select_in(cds), .write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n),
    .host_data_bus_in(wire_bus), .host_data_bus_out(dbus_out), .host_data_bus_oe_out(oe),
    .pixel_clock_in(pclk), .enable_in(en), .bus_style_strap_in(1'b1), .bus_width_strap2_in(1'b0),
    .extended_cmd_strap_in(1'b1), .gate_line_out(gline), .gate_strobe_out(gstb),
    .frame_start_out(fstart), .osc_freq_adjust_out(osc), .neg_gamma_tap_out(gamma),
    .tearing_effect_out(te), .vsync_out(vs), .test_output_out(tst), .standby_out(stby));

  gso_host_pins host (.clk_in(clk_in), .read_req_in(read_req), .dev_data_in(dbus_out),
    .dev_oe_in(oe), .chip_select_n_out(cs_n), .cmd_data_select_out(cds),
    .write_strobe_n_out(wr_n), .read_strobe_n_out(rd_n), .pixel_clock_out(pclk),
    .enable_out(en), .bus_wire_out(wire_bus));

  // =========================================================
  // Bus tasks and comparison
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask : rd

  task automatic pins_low();
    check("tearing_effect", 32'(te), 32'h0);
    check("vsync", 32'(vs), 32'h0);
    check("test_output", 32'(tst), 32'h0);
    check("bus_oe", 32'(oe), 32'h0);
  endtask : pins_low

  task automatic wait_strobe();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (gstb !== 1'b1 && n < 40);
    if (n >= 40) check("gate_strobe", 32'(gstb), 32'h1);
  endtask : wait_strobe

  // Expected gate line of step i for mode m = {interlace_select, reverse_direction}
  function automatic logic [31:0] exp_line(input int m, input int i);
    int k;
    k = i % 320;
    case (m)
      0: return 32'(k + 1);
      1: return 32'(320 - k);
      2: return 32'((k < 160) ? 2 * k + 1 : 2 * k - 318);
      default: return 32'((k < 160) ? 320 - 2 * k : 639 - 2 * k);
    endcase
  endfunction : exp_line

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Four full frames at the reset line period, with margin
  initial begin
    #400us;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    #1;
    pins_low();
    check("gate_line", 32'(gline), 32'h1);
    rd(gso_pkg::ADDR_OSC_ADJ, v);
    check("osc_adj_reset", v, 32'(gso_pkg::OSC_ADJ_RESET));
    check("osc_out_reset", 32'(osc), 32'(gso_pkg::OSC_ADJ_RESET));
    rd(gso_pkg::ADDR_LINE_PERIOD, v);
    check("line_period_reset", v, 32'(gso_pkg::LINE_PERIOD_RST));
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d);
      rd(rows[r].a, v);
      check("reg_readback", v, rows[r].e);
      if (rows[r].a == 4'h1) check("osc_out", 32'(osc), rows[r].d);
      if (rows[r].a == 4'h2) check("gamma_taps", 32'(gamma), rows[r].d);
      if (rows[r].a == 4'h6) check("standby", 32'(stby), 32'h1);
    end
    // Soft reset between orders also clears pins left enabled by the first run
    for (int m = 0; m < 4; m++) begin
      wr(gso_pkg::ADDR_SOFT_RESET, 32'h1);
      repeat (2) @(posedge clk_in);
      #1;
      pins_low();
      check("osc_after_soft", 32'(osc), 32'(gso_pkg::OSC_ADJ_RESET));
      if (m == 0) wr(gso_pkg::ADDR_PIN_CTRL, 32'h7);
      wr(gso_pkg::ADDR_SCAN_CTRL, 32'(4 + m));
      for (int i = 0; i <= 320; i++) begin
        wait_strobe();
        check("frame_start", 32'(fstart), 32'(i % 320 == 0));
        // Line number follows its strobe by one cycle
        @(posedge clk_in);
        #1;
        check("gate_line", 32'(gline), exp_line(m, i));
        if (m == 0 && i == 0) begin
          check("tearing_pulse", 32'(te), 32'h1);
          check("vsync_pulse", 32'(vs), 32'h1);
          check("test_pulse", 32'(tst), 32'h1);
        end
      end
    end
    // Reset arriving while the host reads must take the bus drivers off
    @(posedge clk_in);
    read_req <= 1'b1;
    for (int n = 0; n < 20 && oe !== 1'b1; n++) begin
      @(posedge clk_in);
      #1;
    end
    check("bus_oe_read", 32'(oe), 32'h1);
    check("bus_wire", 32'(wire_bus), 32'(gline));
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (3) begin
      @(posedge clk_in);
      #1;
      check("bus_oe_in_reset", 32'(oe), 32'h0);
    end
    @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    #1;
    pins_low();
    check("gate_line_reset", 32'(gline), 32'h1);
    read_req <= 1'b0;
    finish_test();
  end
endmodule : gso_scan_order_pin_states_tb_top
`default_nettype wire
